// >>> core/servo_signal_interface_mux.sv
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`include "sig_if_defines.svh"
module servo_signal_interface_mux
   import sig_if_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Shared input pins, then ref, limit and stop pins, low index first
   input wire logic [5:0] addr_in,
   input wire logic addr6_teach_in,
   input wire logic [2:0] rate_in,
   input wire logic [1:0] profile_in,
   input wire logic pos_capture_a,
   input wire logic pos_capture_b,
   input wire logic ref_in,
   input wire logic limit_cw_in,
   input wire logic limit_ccw_in,
   input wire logic stop_in,
   // Output pins
   output logic auto_mode_ack,
   output logic job_extra_info,
   output logic job_done,
   output logic job_error,
   output logic drive_ready_out,
   output logic trigger_out,
   output logic motor_energised_out,
   // Decoded functions towards the motion core
   output bus_cfg_t bus_cfg,
   output manual_req_t manual_req,
   output logic [13:0] gen_inputs,
   output logic capture_a_evt,
   output logic capture_b_evt,
   output logic ref_active,
   output logic motion_halt
);
   typedef struct packed {
      logic aw_done;
      logic w_done;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [31:0] ctrl;
      logic [3:0] in_en;
      logic [3:0] in_pol;
      logic [4:0] gpo;
      logic [3:0] motion;
      logic sampled;
      bus_cfg_t cfg;
      manual_req_t man;
      logic [13:0] gin;
      logic [1:0] cap_prev;
      logic cap_a;
      logic cap_b;
      logic ref_act;
      logic halt;
      logic [6:0] q;
   } state_t;

   state_t st_r;
   state_t st_nxt;
   logic [17:0] pins_s;
   logic [1:0] mode;
   logic [3:0] opstate;
   logic [3:0] active_lvl;
   logic fixed;

   // every pin passes the three-stage synchroniser
   sig_sync3 #(.W(18)) u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .d({stop_in, limit_ccw_in, limit_cw_in, ref_in, pos_capture_b, pos_capture_a,
          profile_in, rate_in, addr6_teach_in, addr_in}),
      .q(pins_s)
   );

   // Rates without a defined meaning on every bus module count as reserved
   function automatic logic rate_reserved(input logic [2:0] code);
      return code > 3'h5;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction

   assign mode = st_r.ctrl[`CTRL_MODE_LSB +: 2];
   assign opstate = st_r.ctrl[`CTRL_OPSTATE_LSB +: 4];
   assign fixed = (mode == `MODE_FIXED);

   // polarity select 1 = active high; reset leaves all active low
   assign active_lvl = (pins_s[17:14] ^ ~st_r.in_pol) & st_r.in_en;

   always_comb begin
      logic [31:0] merged;
      st_nxt = st_r;
      merged = '0;
      // Write channel: address and data in either order
      if (s_axi_awvalid && !st_r.aw_done) begin
         st_nxt.aw_done = 1'b1;
         st_nxt.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_r.w_done) begin
         st_nxt.w_done = 1'b1;
         st_nxt.wdata = s_axi_wdata;
         st_nxt.wstrb = s_axi_wstrb;
      end
      if (st_r.aw_done && st_r.w_done && !st_r.bvalid) begin
         st_nxt.aw_done = 1'b0;
         st_nxt.w_done = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = 2'h0;
         case (st_r.awaddr)
            `REG_CTRL: begin
               st_nxt.ctrl = merge(st_r.ctrl, st_r.wdata, st_r.wstrb);
            end
            `REG_CFG: begin
               merged = merge({24'h0, st_r.in_pol, st_r.in_en}, st_r.wdata, st_r.wstrb);
               st_nxt.in_en = merged[3:0];
               st_nxt.in_pol = merged[7:4];
            end
            `REG_OUTS: begin
               merged = merge({27'h0, st_r.gpo}, st_r.wdata, st_r.wstrb);
               st_nxt.gpo = merged[4:0];
            end
            `REG_MOTION: begin
               merged = merge({28'h0, st_r.motion}, st_r.wdata, st_r.wstrb);
               st_nxt.motion = merged[3:0];
            end
            default: begin
               st_nxt.bresp = 2'h2;
            end
         endcase
      end
      if (st_r.bvalid && s_axi_bready) begin
         st_nxt.bvalid = 1'b0;
      end
      // Read channel
      if (s_axi_arvalid && !st_r.rvalid) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp = 2'h0;
         case (s_axi_araddr)
            `REG_CTRL: st_nxt.rdata = st_r.ctrl;
            `REG_STAT: st_nxt.rdata = {16'h0, 1'b0, st_r.halt, st_r.ref_act, st_r.sampled,
                                       st_r.cfg.bus_active, st_r.cfg.rate_bad,
                                       st_r.cfg.profile, 1'b0, st_r.cfg.addr};
            `REG_CFG: st_nxt.rdata = {24'h0, st_r.in_pol, st_r.in_en};
            `REG_INPUTS: st_nxt.rdata = {18'h0, st_r.gin};
            `REG_OUTS: st_nxt.rdata = {27'h0, st_r.gpo};
            `REG_MOTION: st_nxt.rdata = {28'h0, st_r.motion};
            default: begin
               st_nxt.rdata = 32'h0000_0000;
               st_nxt.rresp = 2'h2;
            end
         endcase
      end else if (st_r.rvalid && s_axi_rready) begin
         st_nxt.rvalid = 1'b0;
      end

      // one capture in fieldbus mode when the I/O supply is reported up
      if (mode == `MODE_FIELDBUS && st_r.ctrl[`CTRL_POWER_UP_BIT] && !st_r.sampled) begin
         st_nxt.sampled = 1'b1;
         st_nxt.cfg.addr = pins_s[6:0];
         st_nxt.cfg.rate = pins_s[9:7];
         st_nxt.cfg.profile = pins_s[11:10];
         st_nxt.cfg.rate_bad = rate_reserved(pins_s[9:7]);
         st_nxt.cfg.bus_active = !rate_reserved(pins_s[9:7]);
      end
      // Supply drop re-arms the capture for the next power-up
      if (!st_r.ctrl[`CTRL_POWER_UP_BIT]) begin
         st_nxt.sampled = 1'b0;
      end

      // general inputs only in free mode
      if (mode == `MODE_FREE) begin
         // General 8-13 are address 0-5, general 7 is address 6
         st_nxt.gin = {pins_s[5:0], pins_s[6], pins_s[13:7]};
      end else begin
         st_nxt.gin = '0;
      end

      if (fixed) begin
         st_nxt.man.list_sel = pins_s[5:0];
         st_nxt.man.teach = pins_s[6];
         st_nxt.man.jog_cw = pins_s[7];
         st_nxt.man.jog_ccw = pins_s[8];
         st_nxt.man.jog_speed_sel = pins_s[9];
         st_nxt.man.enable = pins_s[10];
         st_nxt.man.auto_manual_sel = pins_s[11];
         st_nxt.man.clear_err = pins_s[12];
      end else begin
         st_nxt.man = '0;
      end

      // capture edges; first pin lost to error clear in fixed mode
      st_nxt.cap_prev = pins_s[13:12];
      st_nxt.cap_a = !fixed && pins_s[12] && !st_r.cap_prev[0];
      st_nxt.cap_b = pins_s[13] && !st_r.cap_prev[1];

      // disabled limits never halt
      // Synchroniser clears low, so active-low lines read active for a few cycles
      // after reset; a short halt then errs on the safe side
      st_nxt.ref_act = active_lvl[0];
      st_nxt.halt = |active_lvl[3:1];

      if (fixed) begin
         st_nxt.q[0] = st_r.man.auto_manual_sel;
         st_nxt.q[1] = st_r.motion[`MOT_EXTRA_BIT];
         st_nxt.q[2] = st_r.motion[`MOT_DONE_BIT] && st_r.motion[`MOT_STANDSTILL_BIT];
         st_nxt.q[3] = st_r.motion[`MOT_ERROR_BIT];
      end else begin
         st_nxt.q[3:0] = st_r.gpo[3:0];
      end
      if (fixed) begin
         st_nxt.q[4] = opstate >= `OPSTATE_READY_LO && opstate <= `OPSTATE_READY_HI;
      end else begin
         st_nxt.q[4] = st_r.gpo[4];
      end
      st_nxt.q[5] = st_r.ctrl[`CTRL_TRIGGER_BIT];
      st_nxt.q[6] = st_r.ctrl[`CTRL_ENERGISED_BIT];
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_r <= '0;
         st_r.ctrl <= `CTRL_RESET;
         st_r.in_en <= `IN_EN_RESET;
         st_r.in_pol <= `IN_POL_RESET;
         st_r.gpo <= `GPO_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign s_axi_awready = !st_r.aw_done;
   assign s_axi_wready = !st_r.w_done;
   assign s_axi_bvalid = st_r.bvalid;
   assign s_axi_bresp = st_r.bresp;
   assign s_axi_arready = !st_r.rvalid;
   assign s_axi_rvalid = st_r.rvalid;
   assign s_axi_rdata = st_r.rdata;
   assign s_axi_rresp = st_r.rresp;
   assign {motor_energised_out, trigger_out, drive_ready_out, job_error, job_done,
           job_extra_info, auto_mode_ack} = st_r.q;
   assign bus_cfg = st_r.cfg;
   assign manual_req = st_r.man;
   assign gen_inputs = st_r.gin;
   assign capture_a_evt = st_r.cap_a;
   assign capture_b_evt = st_r.cap_b;
   assign ref_active = st_r.ref_act;
   assign motion_halt = st_r.halt;

   a_ready_range: assert property (@(posedge clk) disable iff (!reset_n)
      fixed |=> drive_ready_out == ($past(opstate) >= 4'h4 && $past(opstate) <= 4'h7))
      else $error("ready output outside states 4 to 7");
   a_halt_limit: assert property (@(posedge clk) disable iff (!reset_n)
      active_lvl[1] |=> motion_halt)
      else $error("limit did not halt movement");
   a_limit_disabled: assert property (@(posedge clk) disable iff (!reset_n)
      !(|st_r.in_en[3:1]) |=> !motion_halt)
      else $error("disabled limits halted movement");
   a_rate_bad: assert property (@(posedge clk) disable iff (!reset_n)
      st_r.cfg.rate_bad |-> !st_r.cfg.bus_active)
      else $error("bus active with reserved rate");
   a_gin_mode: assert property (@(posedge clk) disable iff (!reset_n)
      mode != `MODE_FREE |=> gen_inputs == 14'h0000)
      else $error("general inputs outside free mode");
   a_done_fixed: assert property (@(posedge clk) disable iff (!reset_n)
      fixed && $stable(st_r.motion) && !st_r.motion[`MOT_STANDSTILL_BIT] |=> !job_done)
      else $error("job done while moving");
   a_ack_follows: assert property (@(posedge clk) disable iff (!reset_n)
      fixed && $rose(pins_s[11]) |-> ##2 (auto_mode_ack || !fixed))
      else $error("acknowledge missed select");
   a_cap_fixed: assert property (@(posedge clk) disable iff (!reset_n)
      fixed |=> !capture_a_evt)
      else $error("capture a used in fixed mode");
   a_trigger_list: assert property (@(posedge clk) disable iff (!reset_n)
      trigger_out == $past(st_r.ctrl[`CTRL_TRIGGER_BIT]))
      else $error("trigger output does not follow control bit");
   a_energised_brake: assert property (@(posedge clk) disable iff (!reset_n)
      motor_energised_out == $past(st_r.ctrl[`CTRL_ENERGISED_BIT]))
      else $error("energised output does not follow control bit");
   a_error_fixed: assert property (@(posedge clk) disable iff (!reset_n)
      fixed |=> job_error == $past(st_r.motion[`MOT_ERROR_BIT]))
      else $error("job error output wrong in fixed mode");
   a_extra_fixed: assert property (@(posedge clk) disable iff (!reset_n)
      fixed |=> job_extra_info == $past(st_r.motion[`MOT_EXTRA_BIT]))
      else $error("job extra info output wrong in fixed mode");
   a_ack_free: assert property (@(posedge clk) disable iff (!reset_n)
      !fixed |=> auto_mode_ack == $past(st_r.gpo[0]))
      else $error("general output 0 wrong outside fixed mode");
   a_list_sel: assert property (@(posedge clk) disable iff (!reset_n)
      fixed |=> manual_req.list_sel == $past(pins_s[5:0]))
      else $error("list select does not follow its pins");
   a_jog_fixed: assert property (@(posedge clk) disable iff (!reset_n)
      fixed |=> manual_req.jog_cw == $past(pins_s[7]) && manual_req.jog_ccw == $past(pins_s[8]))
      else $error("jog requests do not follow their pins");
   a_teach_fixed: assert property (@(posedge clk) disable iff (!reset_n)
      fixed |=> manual_req.teach == $past(pins_s[6]))
      else $error("teach request does not follow its pin");
   a_cfg_held: assert property (@(posedge clk) disable iff (!reset_n)
      st_r.sampled && $past(st_r.sampled) |-> $stable(bus_cfg))
      else $error("bus setting changed after capture");
   a_halt_stop: assert property (@(posedge clk) disable iff (!reset_n)
      active_lvl[2] || active_lvl[3] |=> motion_halt)
      else $error("limit or stop did not halt movement");
endmodule // servo_signal_interface_mux

// >>> core/sig_if_defines.svh
`ifndef SIG_IF_DEFINES_SVH
`define SIG_IF_DEFINES_SVH

// Byte addresses of the registers
`define REG_CTRL 8'h00
`define REG_STAT 8'h04
`define REG_CFG 8'h08
`define REG_INPUTS 8'h0C
`define REG_OUTS 8'h10
`define REG_MOTION 8'h14

// Control register fields
`define CTRL_MODE_LSB 0
`define CTRL_OPSTATE_LSB 4
`define CTRL_ENERGISED_BIT 8
`define CTRL_TRIGGER_BIT 9
`define CTRL_POWER_UP_BIT 10

// Motion status register fields (written by motion core via software)
`define MOT_EXTRA_BIT 0
`define MOT_DONE_BIT 1
`define MOT_ERROR_BIT 2
`define MOT_STANDSTILL_BIT 3

// Reset values
`define CTRL_RESET 32'h0000_0000
`define IN_EN_RESET 4'hF
`define IN_POL_RESET 4'h0
`define GPO_RESET 5'h00

`define MODE_FIELDBUS 2'h0
`define MODE_FREE 2'h1
`define MODE_FIXED 2'h2
`define OPSTATE_READY_LO 4'h4
`define OPSTATE_READY_HI 4'h7
`endif

// >>> core/sig_if_pkg.sv
package sig_if_pkg;
   typedef struct packed {
      logic [6:0] addr;
      logic [2:0] rate;
      logic [1:0] profile;
      logic rate_bad;
      logic bus_active;
   } bus_cfg_t;

   typedef struct packed {
      logic jog_cw;
      logic jog_ccw;
      logic jog_speed_sel;
      logic auto_manual_sel;
      logic enable;
      logic teach;
      logic clear_err;
      logic [5:0] list_sel;
   } manual_req_t;
endpackage

// >>> core/sig_sync3.sv
module sig_sync3 #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] q_r;

   // A bit changes once the second and third stages agree
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         q_r <= '0;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         for (int i = 0; i < W; i++) begin
            if (s2_r[i] == s3_r[i]) begin
               q_r[i] <= s3_r[i];
            end
         end
      end
   end
   assign q = q_r;
endmodule // sig_sync3

// >>> bench/sig_field_model.sv
module sig_field_model (
   // Clock
   input wire logic clk,
   // Levels asked for by the bench: [13:0] shared pins, [17:14] ref, cw, ccw, stop
   input wire logic [17:0] want,
   // Pin levels seen by the controller
   output logic [17:0] pins
);
   timeunit 1ns;
   timeprecision 1ps;
   // Unused limit and stop lines are tied to the inactive supply level
   initial pins = 18'h3C000;
   // Switches change just after an edge, so no level lands in the edge itself
   always @(posedge clk) begin
      pins <= want;
   end
endmodule // sig_field_model

// >>> bench/servo_signal_interface_mux_test.sv
module servo_signal_interface_mux_test
   import sig_if_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // Model register plus synchroniser, decode and pin output stages
   localparam int SETTLE = 8;
   typedef struct packed {
      logic [1:0] mode;
      logic [3:0] op;
      logic [3:0] mot;
      logic [4:0] gpo;
      logic [1:0] et;
      logic [13:0] p;
      logic [6:0] o;
   } row_t;
   logic clk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [1:0] s_axi_bresp, s_axi_rresp, r, b;
   logic [3:0] s_axi_wstrb;
   logic [17:0] want, pins;
   logic [13:0] gen_inputs, g;
   logic [12:0] m;
   logic [6:0] outs;
   bus_cfg_t bus_cfg;
   manual_req_t manual_req;
   logic capture_a_evt, capture_b_evt, ref_active, motion_halt;
   int errors, samples_checked, cycles, n;
   row_t rows [6] = '{
      '{2'h1, 4'h5, 4'hF, 5'h15, 2'h1, 14'h2A5A, 7'h35},
      '{2'h1, 4'h0, 4'h0, 5'h0A, 2'h2, 14'h15A5, 7'h4A},
      '{2'h2, 4'h4, 4'hB, 5'h00, 2'h3, 14'h0B2D, 7'h77},
      '{2'h2, 4'h7, 4'h6, 5'h1F, 2'h0, 14'h3455, 7'h18},
      '{2'h2, 4'h8, 4'h2, 5'h1F, 2'h0, 14'h0000, 7'h00},
      '{2'h2, 4'h3, 4'hA, 5'h00, 2'h1, 14'h0800, 7'h25}};
   // {cfg, levels of stop ccw cw ref, {halt, ref_active}}
   logic [13:0] lim [8] = '{{8'h0F, 4'hF, 2'h0}, {8'h0F, 4'hE, 2'h1}, {8'h0F, 4'hD, 2'h2},
                            {8'h0F, 4'hB, 2'h2}, {8'h0F, 4'h7, 2'h2}, {8'h0D, 4'hD, 2'h0},
                            {8'h2F, 4'hF, 2'h2}, {8'h01, 4'h0, 2'h1}};
   sig_field_model u_model (.clk(clk), .want(want), .pins(pins));
   servo_signal_interface_mux u_dut (.clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .addr_in(pins[5:0]), .addr6_teach_in(pins[6]), .rate_in(pins[9:7]),
      .profile_in(pins[11:10]), .pos_capture_a(pins[12]), .pos_capture_b(pins[13]),
      .ref_in(pins[14]), .limit_cw_in(pins[15]), .limit_ccw_in(pins[16]),
      .stop_in(pins[17]), .auto_mode_ack(outs[0]), .job_extra_info(outs[1]),
      .job_done(outs[2]), .job_error(outs[3]), .drive_ready_out(outs[4]),
      .motor_energised_out(outs[5]), .trigger_out(outs[6]), .bus_cfg, .manual_req,
      .gen_inputs, .capture_a_evt, .capture_b_evt, .ref_active, .motion_halt);
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         end_of_test();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         errors++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      b = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic settle;
      repeat (SETTLE) @(posedge clk);
   endtask
   task automatic end_of_test;
      if (errors == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      {clk, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      want = 18'h3C000;
      reset_n = 1'b0;
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      chk("outs_reset", 32'h0, {25'h0, outs});
      rd(8'h08);
      chk("cfg_reset", 32'h0000000F, d);
      rd(8'h00);
      chk("ctrl_reset", 32'h0, d);
      rd(8'h20);
      chk("unmapped_resp", 32'h2, {30'h0, r});
      chk("unmapped_data", 32'h0, d);
      foreach (rows[i]) begin
         wr(8'h00, {22'h0, rows[i].et, rows[i].op, 2'h0, rows[i].mode});
         wr(8'h10, {27'h0, rows[i].gpo});
         wr(8'h14, {28'h0, rows[i].mot});
         want <= {4'hF, rows[i].p};
         settle();
         chk("pin_outs", {25'h0, rows[i].o}, {25'h0, outs});
         if (rows[i].mode == 2'h1) begin
            g = {rows[i].p[5:0], rows[i].p[6], rows[i].p[13:7]};
            chk("gen_inputs", {18'h0, g}, {18'h0, gen_inputs});
            chk("manual_req_m1", 32'h0, {19'h0, manual_req});
            rd(8'h0C);
            chk("inputs_reg", {18'h0, g}, d);
         end else begin
            chk("gen_inputs_m2", 32'h0, {18'h0, gen_inputs});
            m = {rows[i].p[7], rows[i].p[8], rows[i].p[9], rows[i].p[11], rows[i].p[10],
                 rows[i].p[6], rows[i].p[12], rows[i].p[5:0]};
            chk("manual_req", {19'h0, m}, {19'h0, manual_req});
         end
      end
      // Address 7'h51, rate 5, profile 2 presented before the supply comes up
      want <= 18'h3CAD1;
      wr(8'h00, 32'h0);
      settle();
      wr(8'h00, 32'h400);
      settle();
      chk("bus_cfg", {18'h0, 7'h51, 3'h5, 2'h2, 2'b01}, {18'h0, bus_cfg});
      want <= 18'h3C000;
      settle();
      chk("bus_cfg_held", {18'h0, 7'h51, 3'h5, 2'h2, 2'b01}, {18'h0, bus_cfg});
      wr(8'h00, 32'h0);
      want <= 18'h3C380;
      settle();
      wr(8'h00, 32'h400);
      settle();
      chk("rate_reserved", {18'h0, 7'h00, 3'h7, 2'h0, 2'b10}, {18'h0, bus_cfg});
      rd(8'h04);
      chk("stat_reg", 32'h0000_1400, d);
      wr(8'h00, 32'h1);
      foreach (lim[i]) begin
         wr(8'h08, {24'h0, lim[i][13:6]});
         want <= {lim[i][5:2], 14'h0};
         settle();
         chk("halt_ref", {30'h0, lim[i][1:0]}, {30'h0, motion_halt, ref_active});
      end
      wr(8'h08, 32'h0000000F);
      for (int i = 0; i < 2; i++) begin
         want <= 18'h3C000;
         settle();
         n = 0;
         want <= 18'h3C000 | (18'h1000 << i);
         repeat (SETTLE + 4) begin
            @(posedge clk);
            n += int'(i ? capture_b_evt : capture_a_evt);
         end
         chk("capture_pulses", 32'h1, n);
      end
      // Read-only offset answers with an error response
      wr(8'h04, 32'h0000_FFFF);
      chk("ro_write_resp", 32'h2, {30'h0, b});
      wr(8'h10, 32'h0000_0003);
      chk("write_resp", 32'h0, {30'h0, b});
      // Byte lane 0 disabled leaves the general outputs alone
      s_axi_wstrb <= 4'hE;
      wr(8'h10, 32'h0000_001C);
      s_axi_wstrb <= 4'hF;
      rd(8'h10);
      chk("wstrb_lanes", 32'h3, d);
      // Mid-run reset must bring back the reset values
      reset_n <= 1'b0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      chk("outs_midrun", 32'h0, {25'h0, outs});
      rd(8'h08);
      chk("cfg_midrun", 32'h0000000F, d);
      end_of_test();
   end
endmodule // servo_signal_interface_mux_test
